//--- hdl/bridge_pkg.sv
package bridge_pkg;

   // ****************************************
   // Sizes and timing.
   // ****************************************
   localparam int DATA_W = 32;
   localparam int REGIONS = 4;
   localparam int FIFO_DEPTH = 8;
   localparam logic [4:0] FIRST_WAIT = 5'h10;
   localparam logic [4:0] LATER_WAIT = 5'h08;
   localparam logic [31:0] ADDR_STEP = 32'h0000_0004;

   // ****************************************
   // Bus commands that are claimed.
   // ****************************************
   localparam logic [3:0] CMD_IO_RD = 4'h2;
   localparam logic [3:0] CMD_IO_WR = 4'h3;
   localparam logic [3:0] CMD_MEM_RD = 4'h6;
   localparam logic [3:0] CMD_MEM_WR = 4'h7;
   localparam logic [3:0] CMD_MEM_RDM = 4'hC;
   localparam logic [3:0] CMD_MEM_RDL = 4'hE;
   localparam logic [3:0] CMD_MEM_WRI = 4'hF;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_WDATA = 3'h1,
      ST_RWAIT = 3'h3,
      ST_RETRY = 3'h2,
      ST_TURN = 3'h6
   } pci_state_t;

   typedef struct packed {
      logic en;
      logic [31:0] base;
      logic [31:0] mask;
   } region_cfg_t;

   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] data;
      logic [3:0] be_n;
      logic [1:0] region;
      logic burst;
   } wr_entry_t;

   typedef struct packed {
      logic access_attention_n;
      logic burst_flag_n;
      logic [1:0] region_number;
      logic [3:0] byte_lane_enables_n;
      logic write_not_read;
   } addon_status_t;

   localparam int ENTRY_W = $bits(wr_entry_t);

endpackage

//--- hdl/passthru_target_bridge.sv
// How it works
// - Claim read or write cycles hitting a region.
// - Idle and hit: decode command, start add-on.
// - Busy with earlier access: retry new hit, unless it reads the pending read's region.
// - Store cycle address in address register.
// - Write: TRDY at once, latch, flag add-on.
// - Read: flag add-on, finish after data written.
// - Show bursts on burst flag output.
// - Burst write: done frees room for next phase.
// - Address steps with every burst data phase.
// - Burst read: after done drive data, TRDY.
// - Retry after 16 first, 8 later clocks.
// - Retry when burst leaves its region.
// - Pending write keeps registers unchanged.
// - Pending write retries every region access.
// - Only region accesses are claimed or retried.
// - Repeated read after done completes at once.
// - Repeated read waits 16 clocks, else retry.
// - Pending read retries all other regions.
// - Any initiator gets the fetched read data.
// - Data register changes only on clock edges.
// - Status: attention, burst, region, enables, write.

// ****************************************
// Synchronous FIFO.
// ****************************************
module sync_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL = CW'(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0] wptr_q;
   logic [PW-1:0] rptr_q;
   logic [CW-1:0] count_q;
   wire push = i_in_valid && o_in_ready;
   wire pop = o_out_valid && i_out_ready;

   assign o_in_ready = count_q != FULL;
   assign o_out_valid = count_q != '0;
   assign o_out_data = mem_q[rptr_q];

   always_ff @(posedge i_clk) begin
      if (push) begin
         mem_q[wptr_q] <= i_in_data;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         wptr_q <= '0;
         rptr_q <= '0;
         count_q <= '0;
      end else begin
         if (push) begin
            wptr_q <= (wptr_q == PW'(DEPTH - 1)) ? '0 : wptr_q + 1'b1;
         end
         if (pop) begin
            rptr_q <= (rptr_q == PW'(DEPTH - 1)) ? '0 : rptr_q + 1'b1;
         end
         count_q <= count_q + CW'(push) - CW'(pop);
      end
   end
endmodule

// ****************************************
// Pass-through target bridge.
// ****************************************
module passthru_target_bridge (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_frame_n,
   input wire logic i_irdy_n,
   input wire logic [31:0] i_ad,
   input wire logic [3:0] i_cbe_n,
   output logic [31:0] o_ad,
   output logic o_ad_oe,
   output logic o_devsel_n,
   output logic o_devsel_oe,
   output logic o_trdy_n,
   output logic o_trdy_oe,
   output logic o_stop_n,
   output logic o_stop_oe,
   input wire bridge_pkg::region_cfg_t [3:0] i_region_cfg,
   output logic o_buffered_bus_clock,
   output bridge_pkg::addon_status_t o_status,
   output logic [31:0] o_passthru_address_reg,
   output logic [31:0] o_passthru_data_reg,
   input wire logic i_addon_done_n,
   input wire logic i_addon_data_wr,
   input wire logic [31:0] i_addon_data
);
   bridge_pkg::pci_state_t st_q;
   bridge_pkg::pci_state_t st_d;
   bridge_pkg::wr_entry_t push_entry;
   bridge_pkg::wr_entry_t head;
   logic frame_prev_q;
   logic [31:0] ph_addr_q;
   logic [1:0] region_q;
   logic first_q;
   logic [4:0] cnt_q;
   logic rd_pend_q;
   logic rd_ready_q;
   logic rd_burst_q;
   logic [1:0] rd_region_q;
   logic [31:0] rd_addr_q;
   logic [31:0] rd_data_q;
   logic [3:0] rd_be_n_q;
   logic [3:0] hit_now;
   logic [3:0] hit_nxt;
   logic fifo_in_ready;
   logic fifo_out_valid;

   // ****************************************
   // Address decode.
   // ****************************************
   wire [31:0] nxt_addr = ph_addr_q + bridge_pkg::ADDR_STEP;
   genvar g;
   generate
      for (g = 0; g < bridge_pkg::REGIONS; g++) begin : g_dec
         assign hit_now[g] = i_region_cfg[g].en &&
            ((i_ad & i_region_cfg[g].mask) == i_region_cfg[g].base);
         assign hit_nxt[g] = i_region_cfg[g].en &&
            ((nxt_addr & i_region_cfg[g].mask) == i_region_cfg[g].base);
      end
   endgenerate

   wire [1:0] hit_idx = hit_now[0] ? 2'h0 : hit_now[1] ? 2'h1 : hit_now[2] ? 2'h2 : 2'h3;
   wire any_hit = |hit_now;
   wire [3:0] cmd = i_cbe_n;
   wire is_wr = (cmd == bridge_pkg::CMD_IO_WR) || (cmd == bridge_pkg::CMD_MEM_WR) ||
      (cmd == bridge_pkg::CMD_MEM_WRI);
   wire is_rd = (cmd == bridge_pkg::CMD_IO_RD) || (cmd == bridge_pkg::CMD_MEM_RD) ||
      (cmd == bridge_pkg::CMD_MEM_RDM) || (cmd == bridge_pkg::CMD_MEM_RDL);
   wire addr_phase = (st_q == bridge_pkg::ST_IDLE) && !i_frame_n && frame_prev_q;
   wire claim = addr_phase && any_hit && (is_wr || is_rd);

   // ****************************************
   // Admission of a claimed cycle.
   // ****************************************
   wire wr_pend = fifo_out_valid;
   wire free = !wr_pend && !rd_pend_q;
   wire start_wr = claim && is_wr && free;
   wire start_rd = claim && is_rd && free;
   wire resume_rd = claim && is_rd && !wr_pend && rd_pend_q &&
      (hit_idx == rd_region_q);
   wire claim_retry = claim && !start_wr && !start_rd && !resume_rd;

   // ****************************************
   // Data phases.
   // ****************************************
   wire trdy_w = (st_q == bridge_pkg::ST_WDATA) && fifo_in_ready;
   wire trdy_r = (st_q == bridge_pkg::ST_RWAIT) && rd_ready_q;
   wire trdy = trdy_w || trdy_r;
   wire xfer = trdy && !i_irdy_n;
   wire more = xfer && !i_frame_n;
   wire stay_in = hit_nxt[region_q];
   wire [4:0] limit = first_q ? bridge_pkg::FIRST_WAIT : bridge_pkg::LATER_WAIT;
   wire in_phase = (st_q == bridge_pkg::ST_WDATA) || (st_q == bridge_pkg::ST_RWAIT);
   wire timeout = in_phase && !trdy && (cnt_q == limit - 5'h01);
   wire rd_more = trdy_r && more && stay_in;

   always_comb begin
      st_d = st_q;
      case (st_q)
         bridge_pkg::ST_IDLE: begin
            if (start_wr) begin
               st_d = bridge_pkg::ST_WDATA;
            end else if (start_rd || resume_rd) begin
               st_d = bridge_pkg::ST_RWAIT;
            end else if (claim_retry) begin
               st_d = bridge_pkg::ST_RETRY;
            end
         end
         bridge_pkg::ST_WDATA, bridge_pkg::ST_RWAIT: begin
            if (xfer && i_frame_n) begin
               st_d = bridge_pkg::ST_TURN;
            end else if ((more && !stay_in) || timeout) begin
               st_d = bridge_pkg::ST_RETRY;
            end
         end
         bridge_pkg::ST_RETRY: begin
            if (i_frame_n) begin
               st_d = bridge_pkg::ST_TURN;
            end
         end
         bridge_pkg::ST_TURN: st_d = bridge_pkg::ST_IDLE;
         default: st_d = bridge_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         st_q <= bridge_pkg::ST_IDLE;
         frame_prev_q <= 1'b1;
         ph_addr_q <= '0;
         region_q <= '0;
         first_q <= 1'b0;
         cnt_q <= '0;
      end else begin
         st_q <= st_d;
         frame_prev_q <= i_frame_n;
         if (addr_phase) begin
            ph_addr_q <= i_ad;
            region_q <= hit_idx;
            first_q <= 1'b1;
         end else if (xfer) begin
            ph_addr_q <= nxt_addr;
            first_q <= 1'b0;
         end
         cnt_q <= (addr_phase || xfer || !in_phase) ? 5'h00 : cnt_q + 5'h01;
      end
   end

   // ****************************************
   // Write path: phases queue for the add-on.
   // ****************************************
   wire done = !i_addon_done_n;
   assign push_entry.addr = ph_addr_q;
   assign push_entry.data = i_ad;
   assign push_entry.be_n = i_cbe_n;
   assign push_entry.region = region_q;
   assign push_entry.burst = !i_frame_n || !first_q;

   sync_fifo #(
      .WIDTH(bridge_pkg::ENTRY_W),
      .DEPTH(bridge_pkg::FIFO_DEPTH)
   ) u_wr_fifo (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_in_valid(trdy_w && !i_irdy_n),
      .o_in_ready(fifo_in_ready),
      .i_in_data(push_entry),
      .o_out_valid(fifo_out_valid),
      .i_out_ready(done),
      .o_out_data(head)
   );

   // ****************************************
   // Read path: one outstanding fetch.
   // ****************************************
   wire rd_attn = rd_pend_q && !rd_ready_q && !fifo_out_valid;

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         rd_pend_q <= 1'b0;
         rd_ready_q <= 1'b0;
         rd_burst_q <= 1'b0;
         rd_region_q <= '0;
         rd_addr_q <= '0;
         rd_be_n_q <= '0;
         rd_data_q <= '0;
      end else begin
         if (start_rd) begin
            rd_pend_q <= 1'b1;
            rd_burst_q <= 1'b0;
            rd_region_q <= hit_idx;
            rd_addr_q <= i_ad;
         end else if (rd_more) begin
            rd_burst_q <= 1'b1;
            rd_addr_q <= nxt_addr;
         end else if (trdy_r && xfer) begin
            rd_pend_q <= 1'b0;
         end
         if (trdy_r && xfer) begin
            rd_ready_q <= 1'b0;
         end else if (rd_attn && done) begin
            rd_ready_q <= 1'b1;
         end
         if ((st_q == bridge_pkg::ST_RWAIT) && !rd_ready_q) begin
            rd_be_n_q <= i_cbe_n;
         end
         if (rd_pend_q && !rd_ready_q && i_addon_data_wr) begin
            rd_data_q <= i_addon_data;
         end
      end
   end

   // ****************************************
   // Pin and add-on outputs.
   // ****************************************
   assign o_ad = rd_data_q;
   assign o_ad_oe = trdy_r;
   assign o_devsel_n = !(in_phase || st_q == bridge_pkg::ST_RETRY);
   assign o_trdy_n = !trdy;
   assign o_stop_n = st_q != bridge_pkg::ST_RETRY;
   assign o_devsel_oe = st_q != bridge_pkg::ST_IDLE;
   assign o_trdy_oe = st_q != bridge_pkg::ST_IDLE;
   assign o_stop_oe = st_q != bridge_pkg::ST_IDLE;
   assign o_buffered_bus_clock = i_clk;

   assign o_status.access_attention_n = !(fifo_out_valid || rd_attn);
   assign o_status.burst_flag_n = fifo_out_valid ? !head.burst : !rd_burst_q;
   assign o_status.region_number = fifo_out_valid ? head.region : rd_region_q;
   assign o_status.byte_lane_enables_n = fifo_out_valid ? head.be_n : rd_be_n_q;
   assign o_status.write_not_read = fifo_out_valid;
   assign o_passthru_address_reg = fifo_out_valid ? head.addr : rd_addr_q;
   assign o_passthru_data_reg = fifo_out_valid ? head.data : rd_data_q;

   // ****************************************
   // Checks.
   // ****************************************
   property p_claim;
      @(posedge i_clk) disable iff (i_sys_rst)
      claim |=> !o_devsel_n;
   endproperty
   a_claim: assert property (p_claim) else $error("Region hit not claimed.");

   property p_busy_retry;
      @(posedge i_clk) disable iff (i_sys_rst)
      claim && wr_pend |=> !o_stop_n && o_trdy_n;
   endproperty
   a_busy_retry: assert property (p_busy_retry) else $error("No retry on write pending.");

   property p_addr_capture;
      @(posedge i_clk) disable iff (i_sys_rst)
      start_rd |=> o_passthru_address_reg == $past(i_ad) && !o_status.access_attention_n;
   endproperty
   a_addr_capture: assert property (p_addr_capture) else $error("Read address lost.");

   property p_write_trdy;
      @(posedge i_clk) disable iff (i_sys_rst)
      start_wr |=> !o_trdy_n;
   endproperty
   a_write_trdy: assert property (p_write_trdy) else $error("Write TRDY not immediate.");

   property p_read_hold;
      @(posedge i_clk) disable iff (i_sys_rst)
      (st_q == bridge_pkg::ST_RWAIT) && !rd_ready_q |-> o_trdy_n && !o_ad_oe;
   endproperty
   a_read_hold: assert property (p_read_hold) else $error("Read done before add-on.");

   property p_first_timeout;
      @(posedge i_clk) disable iff (i_sys_rst)
      in_phase && first_q && cnt_q == 5'h0F && o_trdy_n |=> !o_stop_n;
   endproperty
   a_first_timeout: assert property (p_first_timeout) else $error("No retry after 16.");

   property p_write_stable;
      @(posedge i_clk) disable iff (i_sys_rst)
      fifo_out_valid && i_addon_done_n |=> $stable(o_passthru_data_reg) &&
         $stable(o_passthru_address_reg);
   endproperty
   a_write_stable: assert property (p_write_stable) else $error("Write data changed.");

   property p_other_region;
      @(posedge i_clk) disable iff (i_sys_rst)
      claim && rd_pend_q && hit_idx != rd_region_q |=> !o_stop_n;
   endproperty
   a_other_region: assert property (p_other_region) else $error("Other region not retried.");
endmodule

//--- test/addon_model.sv
// ****************************************
// Add-on logic model on the far side.
// ****************************************
module addon_model (
   input wire logic i_clk,
   input wire bridge_pkg::addon_status_t i_status,
   input wire logic [31:0] i_addr_reg,
   input wire logic [31:0] i_data_reg,
   input wire logic [5:0] i_delay,
   input wire logic [31:0] i_rd_base,
   output logic o_done_n,
   output logic o_data_wr,
   output logic [31:0] o_data,
   output logic [31:0] o_seen_addr,
   output logic [31:0] o_seen_data,
   output logic o_burst_seen
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [5:0] wait_q;
   initial begin
      o_done_n = 1'b1;
      o_data_wr = 1'b0;
      o_data = 32'h0000_0000;
      o_seen_addr = 32'h0000_0000;
      o_seen_data = 32'h0000_0000;
      o_burst_seen = 1'b0;
      wait_q = 6'h00;
   end
   // Outputs move only just after the falling edge, so each is held across one rising edge.
   always @(negedge i_clk) begin
      if (!i_status.access_attention_n && o_done_n) begin
         if (!i_status.burst_flag_n) begin
            o_burst_seen <= 1'b1;
         end
         if (wait_q >= i_delay) begin
            o_done_n <= 1'b0;
            wait_q <= 6'h00;
            if (i_status.write_not_read) begin
               o_seen_addr <= i_addr_reg;
               o_seen_data <= i_data_reg;
            end else begin
               o_data_wr <= 1'b1;
               o_data <= i_rd_base ^ i_addr_reg;
            end
         end else begin
            wait_q <= wait_q + 6'h01;
         end
      end else begin
         // Released data lines alternate each cycle between the inverse of the last value and the last value itself.
         o_done_n <= 1'b1;
         o_data_wr <= 1'b0;
         o_data <= ~o_data;
      end
   end
endmodule

//--- test/testbench.sv
`define CHECK(what, exp, got) begin check_count++; if ((got) !== (exp)) begin mismatches++; \
   $display("[FAIL] %s expected %h seen %h", what, exp, got); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_clk, i_sys_rst, i_frame_n, i_irdy_n, o_ad_oe, o_devsel_n, o_trdy_n, o_stop_n;
   logic [31:0] i_ad, o_ad, o_passthru_address_reg, o_passthru_data_reg, rd_base;
   logic [31:0] i_addon_data, seen_addr, seen_data;
   logic [3:0] i_cbe_n;
   logic i_addon_done_n, i_addon_data_wr, bclk, burst_seen;
   logic [5:0] delay;
   bridge_pkg::region_cfg_t [3:0] cfg;
   bridge_pkg::addon_status_t o_status;
   logic [31:0] rd [8];
   logic [2:0] oe;
   logic [3:0] oe_seen;
   int mismatches = 0, check_count = 0, cycles = 0, k;
   logic retried;
   passthru_target_bridge dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_frame_n(i_frame_n),
      .i_irdy_n(i_irdy_n), .i_ad(i_ad), .i_cbe_n(i_cbe_n), .o_ad(o_ad), .o_ad_oe(o_ad_oe),
      .o_devsel_n(o_devsel_n), .o_devsel_oe(oe[2]), .o_trdy_n(o_trdy_n), .o_trdy_oe(oe[1]),
      .o_stop_n(o_stop_n), .o_stop_oe(oe[0]), .i_region_cfg(cfg), .o_buffered_bus_clock(bclk),
      .o_status(o_status), .o_passthru_address_reg(o_passthru_address_reg),
      .o_passthru_data_reg(o_passthru_data_reg), .i_addon_done_n(i_addon_done_n),
      .i_addon_data_wr(i_addon_data_wr), .i_addon_data(i_addon_data));
   addon_model addon (.i_clk(bclk), .i_status(o_status), .i_addr_reg(o_passthru_address_reg),
      .i_data_reg(o_passthru_data_reg), .i_delay(delay), .i_rd_base(rd_base),
      .o_done_n(i_addon_done_n), .o_data_wr(i_addon_data_wr), .o_data(i_addon_data),
      .o_seen_addr(seen_addr), .o_seen_data(seen_data), .o_burst_seen(burst_seen));
   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         test_done();
      end
   end
   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // ****************************************
   // Initiator cycle: n phases, counts transfers in k.
   // ****************************************
   task automatic pci(input logic [31:0] addr, input logic [3:0] cmd, input int n,
                      input logic [31:0] wd);
      bit pend, fin;
      pend = 0;
      fin = 0;
      k = 0;
      retried = 1'b0;
      oe_seen = 4'h0;
      @(negedge i_clk);
      i_frame_n = 1'b0;
      i_ad = addr;
      i_cbe_n = cmd;
      @(negedge i_clk);
      i_irdy_n = 1'b0;
      i_frame_n = (n == 1);
      i_ad = cmd[0] ? wd : 32'h0000_0000;
      i_cbe_n = 4'h0;
      // The target's answer is looked at before the rising edge that takes the phase.
      for (int w = 0; w < 60 && !fin; w++) begin
         if (!o_devsel_n && !o_trdy_n) begin
            pend = 1;
            rd[k] = o_ad;
            oe_seen = {o_ad_oe, oe};
         end else if (!o_stop_n) begin
            retried = 1'b1;
            fin = 1;
         end
         if (!fin) begin
            @(negedge i_clk);
         end
         if (pend) begin
            k++;
            pend = 0;
            fin = (k == n);
            i_ad = cmd[0] ? wd + k : 32'h0000_0000;
            i_frame_n = (k >= n - 1);
         end
      end
      i_frame_n = 1'b1;
      i_irdy_n = 1'b1;
      repeat (3) @(negedge i_clk);
   endtask
   // ****************************************
   // Scenarios.
   // ****************************************
   task automatic t_write();
      delay = 6'd20;
      pci(32'h0001_0010, bridge_pkg::CMD_MEM_WR, 1, 32'hA5A5_0001);
      `CHECK("wr phases", 1, k)
      `CHECK("wr oe", 4'h7, oe_seen)
      `CHECK("idle oe", 3'h0, oe)
      `CHECK("attention", 1'b0, o_status.access_attention_n)
      `CHECK("wr flag", 1'b1, o_status.write_not_read)
      `CHECK("burst flag", 1'b1, o_status.burst_flag_n)
      `CHECK("region", 2'h0, o_status.region_number)
      `CHECK("be", 4'h0, o_status.byte_lane_enables_n)
      `CHECK("addr reg", 32'h0001_0010, o_passthru_address_reg)
      pci(32'h0001_0200, bridge_pkg::CMD_IO_WR, 1, 32'h5A5A_0002);
      `CHECK("busy retry", 1'b1, retried)
      `CHECK("data kept", 32'hA5A5_0001, o_passthru_data_reg)
      repeat (25) @(negedge i_clk);
      `CHECK("addon data", 32'hA5A5_0001, seen_data)
      $display("test write done");
   endtask
   task automatic t_read();
      delay = 6'd3;
      rd_base = 32'h1234_0000;
      pci(32'h0001_0204, bridge_pkg::CMD_MEM_RD, 1, 32'h0);
      `CHECK("rd phases", 1, k)
      `CHECK("rd oe", 4'hF, oe_seen)
      `CHECK("rd data", 32'h1235_0204, rd[0])
      delay = 6'd25;
      pci(32'h0001_0208, bridge_pkg::CMD_MEM_RDL, 1, 32'h0);
      `CHECK("slow retry", 1'b1, retried)
      pci(32'h0001_0000, bridge_pkg::CMD_MEM_WRI, 1, 32'h0);
      `CHECK("other retry", 1'b1, retried)
      repeat (20) @(negedge i_clk);
      pci(32'h0001_0208, bridge_pkg::CMD_MEM_RDM, 1, 32'h0);
      `CHECK("repeat done", 1, k)
      `CHECK("repeat data", 32'h1235_0208, rd[0])
      $display("test read done");
   endtask
   task automatic t_burst();
      delay = 6'd1;
      rd_base = 32'h0F0F_0000;
      pci(32'h0002_0040, bridge_pkg::CMD_IO_RD, 3, 32'h0);
      `CHECK("brd phases", 3, k)
      for (int i = 0; i < 3; i++) begin
         `CHECK("brd data", 32'h0F0D_0040 + 4 * i, rd[i])
      end
      delay = 6'd0;
      pci(32'h0003_0100, bridge_pkg::CMD_MEM_WR, 4, 32'hBEEF_0000);
      `CHECK("bwr phases", 4, k)
      repeat (10) @(negedge i_clk);
      `CHECK("bwr last", 32'hBEEF_0003, seen_data)
      `CHECK("bwr addr", 32'h0003_010C, seen_addr)
      `CHECK("burst seen", 1'b1, burst_seen)
      pci(32'h0001_01F8, bridge_pkg::CMD_MEM_WR, 4, 32'hC0DE_0000);
      `CHECK("edge phases", 2, k)
      `CHECK("edge retry", 1'b1, retried)
      repeat (10) @(negedge i_clk);
      pci(32'h0001_0200, bridge_pkg::CMD_MEM_WR, 2, 32'hC0DE_0002);
      `CHECK("next region", 2, k)
      pci(32'h0005_0000, bridge_pkg::CMD_MEM_WR, 1, 32'h0);
      `CHECK("miss phases", 0, k)
      `CHECK("miss retry", 1'b0, retried)
      $display("test burst done");
   endtask
   initial begin
      i_sys_rst = 1'b1;
      i_frame_n = 1'b1;
      i_irdy_n = 1'b1;
      i_ad = 32'h0000_0000;
      i_cbe_n = 4'hF;
      delay = 6'd0;
      rd_base = 32'h0000_0000;
      cfg[0] = {1'b1, 32'h0001_0000, 32'hFFFF_FE00};
      cfg[1] = {1'b1, 32'h0001_0200, 32'hFFFF_FE00};
      cfg[2] = {1'b1, 32'h0002_0000, 32'hFFFF_0000};
      cfg[3] = {1'b1, 32'h0003_0000, 32'hFFFF_0000};
      repeat (4) @(negedge i_clk);
      i_sys_rst = 1'b0;
      t_write();
      t_read();
      t_burst();
      test_done();
   end
endmodule
